// *** rtl/phy_ctrl_regs.svh ***
// register offsets, field positions, the fixed status value and timing for the
// basic mode control and status pair of one port.
// assumes a 5-bit management register address and 16-bit data.
`ifndef PHY_CTRL_REGS_SVH
`define PHY_CTRL_REGS_SVH

// ==========================================================
// offsets
`define CTRL_REG_ADDR 5'h00
`define STAT_REG_ADDR 5'h01

// ==========================================================
// control field positions
`define CTRL_RESET_BIT 15
`define CTRL_LOOPBACK_BIT 14
`define CTRL_SPEED_BIT 13
`define CTRL_AN_EN_BIT 12
`define CTRL_PWRDN_BIT 11
`define CTRL_ISOLATE_BIT 10
`define CTRL_AN_RESTART_BIT 9
`define CTRL_DUPLEX_BIT 8
`define CTRL_COL_TEST_BIT 7

// ==========================================================
// status field positions and fixed part
`define STAT_AN_DONE_BIT 5
`define STAT_REM_FAULT_BIT 4
`define STAT_LINK_BIT 2
`define STAT_JABBER_BIT 1
// t4=0, tx fd/hd=1, 10 fd/hd=1, reserved=0, preamble supp=1, an able=1, ext=1
`define STAT_FIXED_VAL 16'h7849

// ==========================================================
// timing
`define CLK_PERIOD_NS 5
`define LOOPBACK_DEAD_US 500
`define LOOPBACK_DEAD_CYC (`LOOPBACK_DEAD_US * 1000 / `CLK_PERIOD_NS)
`define SOFT_RESET_CYC 16
`define SYNC_STAGES 2

`endif

// *** rtl/phy_ctrl_pkg.sv ***
// types shared by the control register block and its datapath.
// assumes nothing of its surroundings.
package phy_ctrl_pkg;

   // reset sequencer, one-hot
   typedef enum logic [1:0] {
      ST_RESET = 2'b01,
      ST_RUN = 2'b10
   } rst_state_t;

   typedef logic [15:0] reg_word_t;
   typedef logic [4:0] reg_addr_t;
   typedef logic [3:0] nibble_t;

endpackage

// *** rtl/port_ctrl_if.sv ***
// mode bits carried from the register block to the mii datapath.
// assumes both ends run on core_clk.
`timescale 1ns/1ps
interface port_ctrl_if;
   logic loopback;
   logic isolate;
   logic power_down;
   logic col_test;

   modport ctl (
      output loopback,
      output isolate,
      output power_down,
      output col_test
   );
   modport dp (
      input loopback,
      input isolate,
      input power_down,
      input col_test
   );
endinterface

// *** rtl/mii_port_path.sv ***
// mii receive-side steering: loopback, isolate, power down, collision test.
// assumes mac transmit and line receive signals are on core_clk.
`timescale 1ns/1ps
`include "phy_ctrl_regs.svh"
module mii_port_path
   import phy_ctrl_pkg::*;
#(
   parameter int DEAD_CYC = `LOOPBACK_DEAD_CYC
) (
   input wire logic core_clk,
   input wire logic resetn,
   port_ctrl_if.dp cif,
   input wire logic tx_en,
   input wire phy_ctrl_pkg::nibble_t txd,
   input wire logic line_rx_dv,
   input wire phy_ctrl_pkg::nibble_t line_rxd,
   input wire logic line_crs,
   input wire logic line_col,
   output logic rx_dv_q,
   output phy_ctrl_pkg::nibble_t rxd_q,
   output logic crs_q,
   output logic col_q,
   output logic mii_oe_q
);
   localparam int CW = $clog2(DEAD_CYC + 1);

   logic lb_prev_q;
   logic [CW-1:0] dead_q;

   // =======================================================
   // loopback dead time
   // dead time count
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         lb_prev_q <= 1'b0;
         dead_q <= '0;
      end else begin
         lb_prev_q <= cif.loopback;
         if (cif.loopback && !lb_prev_q) begin
            dead_q <= CW'(DEAD_CYC);
         end else if (!cif.loopback) begin
            dead_q <= '0;
         end else if (dead_q != '0) begin
            dead_q <= dead_q - 1'b1;
         end
      end
   end

   // =======================================================
   // receive outputs; powered down or isolated ports stay quiet
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rx_dv_q <= 1'b0;
         rxd_q <= 4'h0;
         crs_q <= 1'b0;
         col_q <= 1'b0;
         mii_oe_q <= 1'b0;
      end else begin
         mii_oe_q <= !cif.isolate && !cif.power_down;
         if (cif.isolate || cif.power_down) begin
            rx_dv_q <= 1'b0;
            rxd_q <= 4'h0;
            crs_q <= 1'b0;
            col_q <= 1'b0;
         end else begin
            // transmit looped back
            // first loopback edge: counter not loaded yet, so hold off too
            if (cif.loopback) begin
               rx_dv_q <= tx_en && lb_prev_q && (dead_q == '0);
               rxd_q <= (lb_prev_q && dead_q == '0) ? txd : 4'h0;
               crs_q <= tx_en;
            end else begin
               rx_dv_q <= line_rx_dv;
               rxd_q <= line_rxd;
               crs_q <= line_crs;
            end
            col_q <= cif.col_test ? tx_en : (line_col && !cif.loopback);
         end
      end
   end
endmodule

// *** rtl/phy_basic_mode_ctrl_status_regs.sv ***
// basic mode control and status registers of one 10/100 port, with the
// mode outputs they steer and the mii receive path they gate.
// assumes the management frame decoder and negotiation logic run on
// core_clk; straps and the power-down pin come straight from pins.
//
// What this block does
// - control 15 starts self-clearing soft reset
// - control 14 loops transmit onto receive
// - suppress loopback rx_dv_q and rxd_q for 500 us
// - control 13 picks speed, strap default
// - control 12 enables negotiation, masks 13/8
// - control 11 powers down all but registers
// - power-down bit ORs in pin
// - control 10 isolates port from mii
// - control 9 restarts negotiation, self-clears
// - writing zero leaves negotiation running
// - control 8 picks duplex, strap default
// - collision test asserts col with tx_en
// - col drops soon after tx_en drops
// - control 6:0 ignore writes, read zero
// - status 15 zero, 14:11 one
// - status 10:7 read zero
// - latched-high bits hold until read
// - latched-low bits hold until read
// - self-setting bits follow their event
// - status 6 reports preamble suppression
// - link bit sets only on read
`timescale 1ns/1ps
`include "phy_ctrl_regs.svh"
module phy_basic_mode_ctrl_status_regs #(
   parameter int LOOPBACK_DEAD_CYC = `LOOPBACK_DEAD_CYC,
   parameter int SOFT_RESET_CYC = `SOFT_RESET_CYC
) (
   input wire logic core_clk,
   input wire logic resetn,
   // management register port
   input wire phy_ctrl_pkg::reg_addr_t reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire phy_ctrl_pkg::reg_word_t reg_wdata,
   output phy_ctrl_pkg::reg_word_t reg_rdata_q,
   output logic reg_rvalid_q,
   // pins
   input wire logic power_down_pin_n,
   input wire logic strap_speed_100,
   input wire logic strap_an_enable,
   input wire logic strap_full_duplex,
   // negotiation and link events
   input wire logic an_started,
   input wire logic an_complete,
   input wire logic link_good,
   input wire logic link_fail,
   input wire logic remote_fault_evt,
   input wire logic jabber_evt,
   // mode outputs
   output logic port_reset_q,
   output logic an_enable_q,
   output logic an_restart_q,
   output logic speed_100_q,
   output logic full_duplex_q,
   output logic power_down_q,
   // mii
   input wire logic tx_en,
   input wire phy_ctrl_pkg::nibble_t txd,
   input wire logic line_rx_dv,
   input wire phy_ctrl_pkg::nibble_t line_rxd,
   input wire logic line_crs,
   input wire logic line_col,
   output logic rx_dv_q,
   output phy_ctrl_pkg::nibble_t rxd_q,
   output logic crs_q,
   output logic col_q,
   output logic mii_oe_q
);
   import phy_ctrl_pkg::*;

   localparam int RCW = $clog2(SOFT_RESET_CYC + 1);

   // address match, shared by read and write decode
   function automatic logic hit(input reg_addr_t a, input reg_addr_t target);
      hit = (a == target);
   endfunction

   // =======================================================
   // pin synchronisers
   logic [`SYNC_STAGES-1:0] pd_sync_q, sp_sync_q, an_sync_q, dx_sync_q;
   logic pd_pin_on, strap_sp, strap_an, strap_dx;

   // pins are asynchronous to core_clk; only the last stage is read
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pd_sync_q <= '0;
         sp_sync_q <= '0;
         an_sync_q <= '0;
         dx_sync_q <= '0;
      end else begin
         pd_sync_q <= {pd_sync_q[0], !power_down_pin_n};
         sp_sync_q <= {sp_sync_q[0], strap_speed_100};
         an_sync_q <= {an_sync_q[0], strap_an_enable};
         dx_sync_q <= {dx_sync_q[0], strap_full_duplex};
      end
   end

   assign pd_pin_on = pd_sync_q[`SYNC_STAGES-1];
   assign strap_sp = sp_sync_q[`SYNC_STAGES-1];
   assign strap_an = an_sync_q[`SYNC_STAGES-1];
   assign strap_dx = dx_sync_q[`SYNC_STAGES-1];

   // =======================================================
   // decode
   logic wr_ctrl;
   logic rd_stat;

   assign wr_ctrl = reg_wr && hit(reg_addr, `CTRL_REG_ADDR);
   assign rd_stat = reg_rd && hit(reg_addr, `STAT_REG_ADDR);

   // =======================================================
   // reset sequencer
   rst_state_t state_q;
   logic [RCW-1:0] rst_cnt_q;
   logic in_reset;

   assign in_reset = (state_q == ST_RESET);

   // hardware reset also runs the sequence, so straps are caught
   // only after the synchronisers have filled
   // soft reset sequence
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_RESET;
         rst_cnt_q <= RCW'(SOFT_RESET_CYC);
      end else begin
         case (state_q)
            ST_RESET: begin
               if (rst_cnt_q == '0) begin
                  state_q <= ST_RUN;
               end else begin
                  rst_cnt_q <= rst_cnt_q - 1'b1;
               end
            end
            ST_RUN: begin
               if (wr_ctrl && reg_wdata[`CTRL_RESET_BIT]) begin
                  state_q <= ST_RESET;
                  rst_cnt_q <= RCW'(SOFT_RESET_CYC);
               end
            end
            default: begin
               state_q <= ST_RESET;
               rst_cnt_q <= RCW'(SOFT_RESET_CYC);
            end
         endcase
      end
   end

   // =======================================================
   // control bits
   logic loopback_q, speed_q, an_en_q, pd_q, isolate_q, duplex_q, col_test_q, restart_q;

   // writes during reset are dropped; straps reload every reset cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         loopback_q <= 1'b0;
         speed_q <= 1'b0;
         an_en_q <= 1'b0;
         pd_q <= 1'b0;
         isolate_q <= 1'b0;
         duplex_q <= 1'b0;
         col_test_q <= 1'b0;
      end else if (in_reset) begin
         loopback_q <= 1'b0;
         speed_q <= strap_sp;
         an_en_q <= strap_an;
         pd_q <= 1'b0;
         isolate_q <= 1'b0;
         duplex_q <= strap_dx;
         col_test_q <= 1'b0;
      end else if (wr_ctrl && !reg_wdata[`CTRL_RESET_BIT]) begin
         loopback_q <= reg_wdata[`CTRL_LOOPBACK_BIT];
         speed_q <= reg_wdata[`CTRL_SPEED_BIT];
         an_en_q <= reg_wdata[`CTRL_AN_EN_BIT];
         pd_q <= reg_wdata[`CTRL_PWRDN_BIT];
         isolate_q <= reg_wdata[`CTRL_ISOLATE_BIT];
         duplex_q <= reg_wdata[`CTRL_DUPLEX_BIT];
         col_test_q <= reg_wdata[`CTRL_COL_TEST_BIT];
      end
   end

   // restart request: held until negotiation reports it started
   // restart only when enabled
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         restart_q <= 1'b0;
      end else if (in_reset) begin
         restart_q <= 1'b0;
      end else if (wr_ctrl && !reg_wdata[`CTRL_RESET_BIT]
                   && reg_wdata[`CTRL_AN_RESTART_BIT] && reg_wdata[`CTRL_AN_EN_BIT]) begin
         restart_q <= 1'b1;
      end else if (an_started) begin
         restart_q <= 1'b0;
      end
   end

   // =======================================================
   // latched status bits
   logic link_q;
   logic rem_fault_q;
   logic jabber_q;

   // an event in the read cycle wins, so it is never lost
   // latched-high hold
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rem_fault_q <= 1'b0;
         jabber_q <= 1'b0;
      end else if (in_reset) begin
         rem_fault_q <= 1'b0;
         jabber_q <= 1'b0;
      end else begin
         if (remote_fault_evt) begin
            rem_fault_q <= 1'b1;
         end else if (rd_stat) begin
            rem_fault_q <= 1'b0;
         end
         if (jabber_evt) begin
            jabber_q <= 1'b1;
         end else if (rd_stat) begin
            jabber_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         link_q <= 1'b0;
      end else if (in_reset || link_fail) begin
         link_q <= 1'b0;
      end else if (rd_stat) begin
         link_q <= link_good;
      end
   end

   // =======================================================
   // read path
   reg_word_t ctrl_view;
   reg_word_t stat_view;

   always_comb begin
      ctrl_view = 16'h0000;
      ctrl_view[`CTRL_RESET_BIT] = in_reset;
      ctrl_view[`CTRL_LOOPBACK_BIT] = loopback_q;
      ctrl_view[`CTRL_SPEED_BIT] = speed_q;
      ctrl_view[`CTRL_AN_EN_BIT] = an_en_q;
      ctrl_view[`CTRL_PWRDN_BIT] = pd_q || pd_pin_on;
      ctrl_view[`CTRL_ISOLATE_BIT] = isolate_q;
      ctrl_view[`CTRL_AN_RESTART_BIT] = restart_q;
      ctrl_view[`CTRL_DUPLEX_BIT] = duplex_q;
      ctrl_view[`CTRL_COL_TEST_BIT] = col_test_q;
   end

   always_comb begin
      stat_view = `STAT_FIXED_VAL;
      stat_view[`STAT_AN_DONE_BIT] = an_complete && an_en_q;
      stat_view[`STAT_REM_FAULT_BIT] = rem_fault_q;
      stat_view[`STAT_LINK_BIT] = link_q;
      stat_view[`STAT_JABBER_BIT] = jabber_q;
   end

   // data is the value before any clear-on-read; unmapped reads zero
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q <= 16'h0000;
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_rd;
         if (reg_rd) begin
            if (hit(reg_addr, `CTRL_REG_ADDR)) begin
               reg_rdata_q <= ctrl_view;
            end else if (hit(reg_addr, `STAT_REG_ADDR)) begin
               reg_rdata_q <= stat_view;
            end else begin
               reg_rdata_q <= 16'h0000;
            end
         end
      end
   end

   // =======================================================
   // mode outputs
   // negotiation masks speed and duplex
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         port_reset_q <= 1'b1;
         an_enable_q <= 1'b0;
         an_restart_q <= 1'b0;
         speed_100_q <= 1'b0;
         full_duplex_q <= 1'b0;
         power_down_q <= 1'b0;
      end else begin
         port_reset_q <= in_reset;
         an_enable_q <= an_en_q;
         an_restart_q <= restart_q;
         // forced values only matter while negotiation is off
         speed_100_q <= an_en_q ? 1'b0 : speed_q;
         full_duplex_q <= an_en_q ? 1'b0 : duplex_q;
         power_down_q <= pd_q || pd_pin_on;
      end
   end

   // =======================================================
   // datapath
   port_ctrl_if cif ();

   assign cif.loopback = loopback_q;
   assign cif.isolate = isolate_q;
   assign cif.power_down = pd_q || pd_pin_on;
   assign cif.col_test = col_test_q;

   mii_port_path #(.DEAD_CYC(LOOPBACK_DEAD_CYC)) u_path (
      .core_clk(core_clk), .resetn(resetn), .cif(cif.dp), .tx_en(tx_en), .txd(txd),
      .line_rx_dv(line_rx_dv), .line_rxd(line_rxd), .line_crs(line_crs), .line_col(line_col),
      .rx_dv_q(rx_dv_q), .rxd_q(rxd_q), .crs_q(crs_q), .col_q(col_q), .mii_oe_q(mii_oe_q)
   );
endmodule

// *** tb/regs_props.sv ***
// checker for the basic mode register block, on top-level ports only.
// assumes one clock, core_clk, and the async active-low resetn.
`timescale 1ns/1ps
module regs_props
   import phy_ctrl_pkg::*;
#(
   parameter int SOFT_RESET_CYC = 4
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire phy_ctrl_pkg::reg_addr_t reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire phy_ctrl_pkg::reg_word_t reg_wdata,
   input wire phy_ctrl_pkg::reg_word_t reg_rdata_q,
   input wire logic reg_rvalid_q,
   input wire logic power_down_pin_n,
   input wire logic an_started,
   input wire logic link_fail,
   input wire logic jabber_evt,
   input wire logic port_reset_q,
   input wire logic an_enable_q,
   input wire logic an_restart_q,
   input wire logic speed_100_q,
   input wire logic full_duplex_q,
   input wire logic power_down_q,
   input wire logic tx_en,
   input wire logic line_col,
   input wire logic rx_dv_q,
   input wire logic col_q,
   input wire logic mii_oe_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   int rst_cnt;
   // ==========================================================
   // reset sequence length counter
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_cnt <= 0;
      end else begin
         rst_cnt <= port_reset_q ? rst_cnt + 1 : 0;
      end
   end
   // ==========================================================
   // properties
   property p_reset_len;
      port_reset_q |-> rst_cnt <= SOFT_RESET_CYC + 1;
   endproperty
   a_reset_len: assert property (p_reset_len) else $error("reset sequence too long");
   property p_soft_reset;
      reg_wr && reg_addr == 5'h00 && reg_wdata[15] && !port_reset_q |-> ##[1:2] port_reset_q;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("soft reset not started");
   property p_an_masks;
      an_enable_q && $past(an_enable_q) |-> !speed_100_q && !full_duplex_q;
   endproperty
   a_an_masks: assert property (p_an_masks) else $error("forced mode leaks");
   property p_pin_pd;
      (!power_down_pin_n && !port_reset_q) [*4] |-> power_down_q;
   endproperty
   a_pin_pd: assert property (p_pin_pd) else $error("pin ignored");
   property p_pd_quiet;
      power_down_q [*2] |-> !mii_oe_q && !rx_dv_q;
   endproperty
   a_pd_quiet: assert property (p_pd_quiet) else $error("mii live in power down");
   property p_restart_clr;
      an_started && !reg_wr ##1 !reg_wr |=> !an_restart_q;
   endproperty
   a_restart_clr: assert property (p_restart_clr) else $error("restart stuck");
   property p_col_off;
      !tx_en && !line_col |=> !col_q;
   endproperty
   a_col_off: assert property (p_col_off) else $error("col held");
   property p_ctrl_rsvd;
      reg_rvalid_q && $past(reg_rd) && $past(reg_addr) == 5'h00 |-> reg_rdata_q[6:0] == 7'h00;
   endproperty
   a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("reserved bits set");
   property p_stat_fixed;
      reg_rvalid_q && $past(reg_rd) && $past(reg_addr) == 5'h01
         |-> (reg_rdata_q & 16'hffc9) == 16'h7849;
   endproperty
   a_stat_fixed: assert property (p_stat_fixed) else $error("fixed bits wrong");
   property p_jabber_hold;
      jabber_evt ##1 !reg_rd ##1 (reg_rd && reg_addr == 5'h01) |=> reg_rdata_q[1];
   endproperty
   a_jabber_hold: assert property (p_jabber_hold) else $error("jabber lost");
   property p_link_fail;
      link_fail ##1 !reg_rd ##1 (reg_rd && reg_addr == 5'h01) |=> !reg_rdata_q[2];
   endproperty
   a_link_fail: assert property (p_link_fail) else $error("link kept");
   c_soft: cover property ($fell(port_reset_q));
   c_restart: cover property ($fell(an_restart_q));
   c_link: cover property (reg_rvalid_q && reg_rdata_q[2]);
endmodule

bind phy_basic_mode_ctrl_status_regs regs_props #(.SOFT_RESET_CYC(SOFT_RESET_CYC)) regs_props_inst (
   .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
   .reg_rvalid_q(reg_rvalid_q), .power_down_pin_n(power_down_pin_n),
   .an_started(an_started), .link_fail(link_fail), .jabber_evt(jabber_evt),
   .port_reset_q(port_reset_q), .an_enable_q(an_enable_q), .an_restart_q(an_restart_q),
   .speed_100_q(speed_100_q), .full_duplex_q(full_duplex_q), .power_down_q(power_down_q),
   .tx_en(tx_en), .line_col(line_col), .rx_dv_q(rx_dv_q), .col_q(col_q), .mii_oe_q(mii_oe_q)
);

// *** tb/mgmt_station.sv ***
// station management model: strobes register reads and writes.
// assumes one request per cycle and a read answer one cycle after it.
`timescale 1ns/1ps
`include "phy_ctrl_regs.svh"
module mgmt_station
   import phy_ctrl_pkg::*;
(
   input wire logic core_clk,
   input wire phy_ctrl_pkg::reg_word_t reg_rdata_q,
   input wire logic reg_rvalid_q,
   output phy_ctrl_pkg::reg_addr_t reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output phy_ctrl_pkg::reg_word_t reg_wdata,
   output logic lost
);
   initial begin
      reg_addr = 5'h1f;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'ha5a5;
      lost = 1'b0;
   end
   // ==========================================================
   // write: released lines show inverted data, never the stale word
   task automatic wr(input reg_addr_t a, input reg_word_t d);
      reg_word_t v;
      v = d;
      if (a == `STAT_REG_ADDR) v[10:7] = 4'h0;
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~v;
   endtask
   // read: bounded wait so a silent design cannot hang the run
   task automatic rd(input reg_addr_t a, output reg_word_t d);
      int n;
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      n = 0;
      #1;
      while (reg_rvalid_q !== 1'b1 && n < 4) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n == 4) lost = 1'b1;
      d = reg_rdata_q;
   endtask
endmodule

// *** tb/phy_basic_mode_ctrl_status_regs_tb_top.sv ***
// self-checking bench for the basic mode register block.
// assumes straps start at speed 100, negotiation on and full duplex.
`timescale 1ns/1ps
`include "phy_ctrl_regs.svh"
module phy_basic_mode_ctrl_status_regs_tb_top;
   import phy_ctrl_pkg::*;
   typedef struct {
      reg_word_t wdata;
      reg_word_t rexp;
      logic [5:0] outs; // an_en speed duplex pd oe restart
   } row_t;
   logic core_clk, resetn, pin_n, an_started, an_complete, link_good, link_fail;
   logic rf_evt, jab_evt, port_reset_q, an_enable_q, an_restart_q, speed_100_q;
   logic full_duplex_q, power_down_q, tx_en, rx_dv_q, crs_q, col_q, mii_oe_q;
   logic reg_wr, reg_rd, reg_rvalid_q, lost, strap_sp, strap_an, strap_dx;
   reg_addr_t reg_addr;
   reg_word_t reg_wdata, reg_rdata_q, d;
   nibble_t txd, rxd_q;
   int failures = 0;
   int checks_done = 0;
   row_t rows[8] = '{'{16'h007f, 16'h0000, 6'b000010}, '{16'h2100, 16'h2100, 6'b011010},
      '{16'h3100, 16'h3100, 6'b100010}, '{16'h0800, 16'h0800, 6'b000100},
      '{16'h0400, 16'h0400, 6'b000000}, '{16'h0200, 16'h0000, 6'b000010},
      '{16'h0100, 16'h0100, 6'b001010}, '{16'h1200, 16'h1200, 6'b100011}};

   phy_basic_mode_ctrl_status_regs #(.LOOPBACK_DEAD_CYC(20), .SOFT_RESET_CYC(4))
   phy_basic_mode_ctrl_status_regs_inst (
      .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .reg_rvalid_q(reg_rvalid_q), .power_down_pin_n(pin_n), .strap_speed_100(strap_sp),
      .strap_an_enable(strap_an), .strap_full_duplex(strap_dx), .an_started(an_started),
      .an_complete(an_complete), .link_good(link_good), .link_fail(link_fail),
      .remote_fault_evt(rf_evt), .jabber_evt(jab_evt), .port_reset_q(port_reset_q),
      .an_enable_q(an_enable_q), .an_restart_q(an_restart_q), .speed_100_q(speed_100_q),
      .full_duplex_q(full_duplex_q), .power_down_q(power_down_q), .tx_en(tx_en), .txd(txd),
      .line_rx_dv(1'b0), .line_rxd(4'h0), .line_crs(1'b0), .line_col(1'b0),
      .rx_dv_q(rx_dv_q), .rxd_q(rxd_q), .crs_q(crs_q), .col_q(col_q), .mii_oe_q(mii_oe_q));
   mgmt_station mgmt_station_inst (
      .core_clk(core_clk), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
      .lost(lost));

   // ==========================================================
   // clock and helpers
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checks_done++;
      if (seen !== want) begin
         failures++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // read and compare; a lost answer ends the run
   task automatic rdc(input reg_addr_t a, input reg_word_t want);
      reg_word_t v;
      mgmt_station_inst.rd(a, v);
      if (lost) begin
         failures++;
         report_and_stop();
      end
      check(v, want);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // bounded wait for the reset sequence to end
   task automatic wait_ready();
      int n;
      for (n = 0; n < 50 && port_reset_q !== 1'b0; n++) begin
         @(posedge core_clk);
         #1;
      end
      if (n == 50) begin
         failures++;
         report_and_stop();
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      {resetn, an_started, an_complete, link_good, link_fail, rf_evt, jab_evt} = '0;
      {pin_n, tx_en, txd, strap_sp, strap_an, strap_dx} = {1'b1, 1'b0, 4'h0, 3'b111};
      repeat (20) @(posedge core_clk);
      resetn <= 1'b1;
      mgmt_station_inst.rd(`CTRL_REG_ADDR, d);
      check(d[15], 1'b1);
      wait_ready();
      rdc(`CTRL_REG_ADDR, 16'h3100);
      rdc(`STAT_REG_ADDR, 16'h7849);
      mgmt_station_inst.wr(`STAT_REG_ADDR, 16'hffff);
      rdc(`STAT_REG_ADDR, 16'h7849);
      $display("reset and fixed values done");
      foreach (rows[i]) begin
         mgmt_station_inst.wr(`CTRL_REG_ADDR, rows[i].wdata);
         wait_cyc(3);
         check({an_enable_q, speed_100_q, full_duplex_q, power_down_q, mii_oe_q, an_restart_q},
            rows[i].outs);
         rdc(`CTRL_REG_ADDR, rows[i].rexp);
      end
      $display("row table done");
      mgmt_station_inst.wr(`CTRL_REG_ADDR, 16'h1000);
      rdc(`CTRL_REG_ADDR, 16'h1200);
      @(posedge core_clk);
      an_started <= 1'b1;
      @(posedge core_clk);
      an_started <= 1'b0;
      wait_cyc(3);
      check(an_restart_q, 1'b0);
      rdc(`CTRL_REG_ADDR, 16'h1000);
      @(posedge core_clk);
      strap_sp <= 1'b0;
      mgmt_station_inst.wr(`CTRL_REG_ADDR, 16'h8800);
      wait_cyc(3);
      wait_ready();
      rdc(`CTRL_REG_ADDR, 16'h1100);
      $display("restart and soft reset done");
      @(posedge core_clk);
      pin_n <= 1'b0;
      wait_cyc(5);
      check(power_down_q, 1'b1);
      rdc(`CTRL_REG_ADDR, 16'h1900);
      pin_n <= 1'b1;
      link_good <= 1'b1;
      wait_cyc(5);
      @(posedge core_clk);
      {jab_evt, rf_evt, link_fail} <= 3'b110;
      @(posedge core_clk);
      {jab_evt, rf_evt} <= 2'b00;
      rdc(`STAT_REG_ADDR, 16'h785b);
      rdc(`STAT_REG_ADDR, 16'h784d);
      @(posedge core_clk);
      link_fail <= 1'b1;
      @(posedge core_clk);
      link_fail <= 1'b0;
      rdc(`STAT_REG_ADDR, 16'h7849);
      an_complete <= 1'b1;
      rdc(`STAT_REG_ADDR, 16'h786d);
      an_complete <= 1'b0;
      rdc(`STAT_REG_ADDR, 16'h784d);
      $display("status latches done");
      mgmt_station_inst.wr(`CTRL_REG_ADDR, 16'h4000);
      tx_en <= 1'b1;
      txd <= 4'h5;
      wait_cyc(1);
      check(rx_dv_q, 1'b0);
      wait_cyc(20);
      check(rx_dv_q, 1'b0);
      wait_cyc(1);
      check({rx_dv_q, crs_q, rxd_q}, 6'h35);
      @(posedge core_clk);
      tx_en <= 1'b0;
      mgmt_station_inst.wr(`CTRL_REG_ADDR, 16'h0080);
      wait_cyc(3);
      @(posedge core_clk);
      tx_en <= 1'b1;
      wait_cyc(3);
      check(col_q, 1'b1);
      @(posedge core_clk);
      tx_en <= 1'b0;
      wait_cyc(3);
      check(col_q, 1'b0);
      $display("loopback and collision test done");
      report_and_stop();
   end
endmodule
